// ### rtl/ges_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1: six engage states, off through wheel steering
// R2: display flag false forces all-off state
// R3: stab flag: no dump, gyro valid, check good
// R4: auto flag: stab, no go-around, trim, monitor
// R5: display flag: gyro valid and check good
// R6: functions on only while flags true
// R7: acceleration dump disengages automatic pilot
// R8: start all-off, stab and auto enables set
// R9: momentary switch needs release before new press; code gives one press for a switch held through reset
// R10: register switches, act on edges, flags each cycle
module ges_top
(
    input  wire logic                       clk_sys_in,   // System clock, 20 MHz
    input  wire logic                       rstn_in,      // Async reset, low
    // Wishbone slave
    input  wire logic                       wb_cyc_in,    // Bus cycle
    input  wire logic                       wb_stb_in,    // Strobe
    input  wire logic                       wb_we_in,     // Write enable
    input  wire logic [ges_pkg::ADDR_W-1:0] wb_adr_in,    // Byte address
    input  wire logic [3:0]                 wb_sel_in,    // Byte lanes
    input  wire logic [ges_pkg::DATA_W-1:0] wb_dat_in,    // Write data
    output logic      [ges_pkg::DATA_W-1:0] wb_dat_out,   // Read data
    output logic                            wb_ack_out,   // Acknowledge
    // Cockpit switches, momentary
    input  wire logic                       disp_btn_in,  // Display button
    input  wire logic                       stab_btn_in,  // Stabiliser button
    input  wire logic                       auto_btn_in,  // Autopilot button
    // Held switches and monitors
    input  wire logic                       wheel_sw_in,  // Wheel steering switch
    input  wire logic                       dump_sw_in,   // Pilot dump switch
    input  wire logic                       gyro_ok_in,   // Attitude gyro valid
    input  wire logic                       check_ok_in,  // Self-check good
    input  wire logic                       goaround_in,  // Go-around switch
    input  wire logic                       trim_man_in,  // Manual trim active
    input  wire logic                       trim_ok_in,   // Trim monitor good
    input  wire logic                       g_dump_in,    // Acceleration dump
    // Engage outputs
    output logic                            disp_on_out,  // Display engaged
    output logic                            stab_on_out,  // Stabiliser engaged
    output logic                            auto_on_out,  // Autopilot engaged
    output logic                            wheel_on_out, // Wheel steering active
    output logic                            irq_out       // Interrupt, high level
);

    import ges_pkg::*;

    // ------------------------------------------------------------
    // Input index map
    // ------------------------------------------------------------
    localparam int N_IN     = 11;        // Synchronised pins
    localparam int I_DISP   = 0;         // Display button
    localparam int I_STAB   = 1;         // Stabiliser button
    localparam int I_AUTO   = 2;         // Autopilot button
    localparam int I_WHEEL  = 3;         // Wheel switch
    localparam int I_DUMP   = 4;         // Pilot dump
    localparam int I_GYRO   = 5;         // Gyro valid
    localparam int I_CHECK  = 6;         // Self-check
    localparam int I_GOAR   = 7;         // Go-around
    localparam int I_TRIM   = 8;         // Manual trim
    localparam int I_TRIMOK = 9;         // Trim monitor
    localparam int I_GDUMP  = 10;        // Acceleration dump

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [N_IN-1:0]   pin_raw;          // Raw pin vector
    logic [N_IN-1:0]   pin_s;            // Synchronised pins
    logic [2:0]        press;            // New-press pulses
    logic              disp_flag;        // Display permission
    logic              stab_flag;        // Stabiliser permission
    logic              auto_flag;        // Autopilot permission
    logic              stab_ok;          // Permission and enable
    logic              auto_ok;          // Permission, enable, no dump
    ges_state_t        state_r;          // Engage state
    ges_state_t        state_nxt;        // Next engage state
    logic [CTRL_W-1:0] ctrl_r;           // Enable control
    logic [CTRL_W-1:0] ctrl_nxt;         // Next control
    logic [IRQ_W-1:0]  irq_stat_r;       // Sticky events
    logic [IRQ_W-1:0]  irq_stat_nxt;     // Next sticky events
    logic [IRQ_W-1:0]  irq_mask_r;       // Event mask
    logic [IRQ_W-1:0]  irq_mask_nxt;     // Next event mask
    logic [IRQ_W-1:0]  event_v;          // Events this cycle
    logic              bus_req;          // New bus request
    logic              bus_wr;           // Write taken this edge
    logic [DATA_W-1:0] rd_data;          // Read multiplexer
    logic              auto_now;         // Autopilot in current state
    logic              auto_next;        // Autopilot in next state

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    // Pins gathered into one vector
    assign pin_raw = {g_dump_in, trim_ok_in, trim_man_in, goaround_in,
                      check_ok_in, gyro_ok_in, dump_sw_in, wheel_sw_in,
                      auto_btn_in, stab_btn_in, disp_btn_in};

    // R10: switches registered on clock
    ges_sync #(
        .W          (N_IN)
    ) u_sync (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .raw_in     (pin_raw),
        .sync_out   (pin_s)
    );

    // R9: release seen before press
    ges_press #(
        .W          (3)
    ) u_press (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .level_in   (pin_s[I_AUTO:I_DISP]),
        .press_out  (press)
    );

    // ------------------------------------------------------------
    // Permission flags, evaluated every cycle
    // ------------------------------------------------------------
    // R5: display needs gyro and check
    assign disp_flag = pin_s[I_GYRO] & pin_s[I_CHECK];

    // R3: stabiliser needs no dump too
    assign stab_flag = ~pin_s[I_DUMP] & pin_s[I_GYRO] & pin_s[I_CHECK];

    // R4: autopilot adds trim conditions
    assign auto_flag = stab_flag & ~pin_s[I_GOAR]
                     & (~pin_s[I_TRIM] | pin_s[I_WHEEL])
                     & pin_s[I_TRIMOK];

    // R6: software enables gate the flags
    assign stab_ok = stab_flag & ctrl_r[CTRL_STAB_EN];

    // R7: acceleration dump blocks autopilot
    assign auto_ok = auto_flag & ctrl_r[CTRL_AUTO_EN] & ~pin_s[I_GDUMP];

    // ------------------------------------------------------------
    // Engage state machine, next state
    // ------------------------------------------------------------
    // Flag losses first, then presses in display/stab/auto order
    always_comb begin
        state_nxt = state_r;
        // R2: display flag false means off
        if (!disp_flag) begin
            state_nxt = GES_ALL_OFF;
        // R6: stabiliser lost drops it and autopilot
        end else if (!stab_ok) begin
            unique case (state_r)
                GES_ALL_OFF:   state_nxt = press[I_DISP] ? GES_DISP : GES_ALL_OFF;
                GES_DISP:      state_nxt = press[I_DISP] ? GES_ALL_OFF : GES_DISP;
                GES_STAB:      state_nxt = GES_ALL_OFF;
                GES_DISP_STAB: state_nxt = GES_DISP;
                GES_ALL_ON:    state_nxt = GES_DISP;
                GES_WHEEL:     state_nxt = GES_DISP;
            endcase
        // R7: autopilot lost keeps display and stab
        end else if (!auto_ok && (state_r == GES_ALL_ON || state_r == GES_WHEEL)) begin
            state_nxt = GES_DISP_STAB;
        end else begin
            // R1: transitions among six states
            unique case (state_r)
                GES_ALL_OFF: begin
                    if (press[I_DISP]) begin
                        state_nxt = GES_DISP;
                    end else if (press[I_STAB]) begin
                        state_nxt = GES_STAB;
                    end else if (press[I_AUTO] && auto_ok) begin
                        state_nxt = GES_ALL_ON;
                    end
                end
                GES_DISP: begin
                    if (press[I_DISP]) begin
                        state_nxt = GES_ALL_OFF;
                    end else if (press[I_STAB]) begin
                        state_nxt = GES_DISP_STAB;
                    end else if (press[I_AUTO] && auto_ok) begin
                        state_nxt = GES_ALL_ON;
                    end
                end
                GES_STAB: begin
                    if (press[I_DISP]) begin
                        state_nxt = GES_DISP_STAB;
                    end else if (press[I_STAB]) begin
                        state_nxt = GES_ALL_OFF;
                    end else if (press[I_AUTO] && auto_ok) begin
                        state_nxt = GES_ALL_ON;
                    end
                end
                GES_DISP_STAB: begin
                    if (press[I_DISP]) begin
                        state_nxt = GES_STAB;
                    end else if (press[I_STAB]) begin
                        state_nxt = GES_DISP;
                    end else if (press[I_AUTO] && auto_ok) begin
                        state_nxt = GES_ALL_ON;
                    end
                end
                GES_ALL_ON: begin
                    // Display stays while autopilot flies
                    if (press[I_STAB]) begin
                        state_nxt = GES_DISP;
                    end else if (press[I_AUTO]) begin
                        state_nxt = GES_DISP_STAB;
                    end else if (pin_s[I_WHEEL]) begin
                        state_nxt = GES_WHEEL;
                    end
                end
                GES_WHEEL: begin
                    // Wheel released returns to full engage
                    if (press[I_STAB]) begin
                        state_nxt = GES_DISP;
                    end else if (press[I_AUTO]) begin
                        state_nxt = GES_DISP_STAB;
                    end else if (!pin_s[I_WHEEL]) begin
                        state_nxt = GES_ALL_ON;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Engage state register
    // ------------------------------------------------------------
    // R8: start in the all-off state
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= GES_ALL_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Engage outputs, decoded from next state
    // ------------------------------------------------------------
    // R6: outputs follow the gated state
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            disp_on_out  <= 1'b0;
            stab_on_out  <= 1'b0;
            auto_on_out  <= 1'b0;
            wheel_on_out <= 1'b0;
        end else begin
            disp_on_out  <= (state_nxt == GES_DISP) || (state_nxt == GES_DISP_STAB)
                         || auto_next;
            stab_on_out  <= (state_nxt == GES_STAB) || (state_nxt == GES_DISP_STAB)
                         || auto_next;
            auto_on_out  <= auto_next;
            wheel_on_out <= (state_nxt == GES_WHEEL);
        end
    end

    // Autopilot engaged in a state
    assign auto_now  = (state_r == GES_ALL_ON) || (state_r == GES_WHEEL);
    assign auto_next = (state_nxt == GES_ALL_ON) || (state_nxt == GES_WHEEL);

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // One request per cycle, acked one edge later
    assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign bus_wr  = bus_req & wb_we_in & wb_sel_in[0];

    // Ack for one cycle, read data with it
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= bus_req;
            // Data only while acked, zero otherwise
            if (bus_req && !wb_we_in) begin
                wb_dat_out <= rd_data;
            end else begin
                wb_dat_out <= 32'h0000_0000;
            end
        end
    end

    // Read multiplexer, unmapped reads zero
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (wb_adr_in)
            OFS_CTRL: begin
                rd_data[CTRL_W-1:0] = ctrl_r;
            end
            OFS_STATUS: begin
                rd_data[STAT_STATE_LSB +: 3] = state_r;
                rd_data[STAT_FLAG_LSB +: 3]  = {auto_flag, stab_flag, disp_flag};
            end
            OFS_IRQ_STAT: begin
                rd_data[IRQ_W-1:0] = irq_stat_r;
            end
            OFS_IRQ_MASK: begin
                rd_data[IRQ_W-1:0] = irq_mask_r;
            end
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Next control on a byte-0 write
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (bus_wr && wb_adr_in == OFS_CTRL) begin
            ctrl_nxt = wb_dat_in[CTRL_W-1:0];
        end
    end

    // R8: enables set at start-up
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_r <= CTRL_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ------------------------------------------------------------
    // Interrupt events, status and mask
    // ------------------------------------------------------------
    // Events taken from the engage machine
    assign event_v[IRQ_CHANGE]    = (state_nxt != state_r);
    assign event_v[IRQ_AUTO_OFF]  = auto_now & ~auto_next;
    assign event_v[IRQ_DISP_LOST] = ~disp_flag & (state_r != GES_ALL_OFF);

    // Write-one-to-clear, a new event wins
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        irq_mask_nxt = irq_mask_r;
        if (bus_wr && wb_adr_in == OFS_IRQ_STAT) begin
            irq_stat_nxt = irq_stat_r & ~wb_dat_in[IRQ_W-1:0];
        end
        if (bus_wr && wb_adr_in == OFS_IRQ_MASK) begin
            irq_mask_nxt = wb_dat_in[IRQ_W-1:0];
        end
        irq_stat_nxt = irq_stat_nxt | event_v;
    end

    // Status and mask registers
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_stat_r <= '0;
            irq_mask_r <= IRQ_MASK_RST;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    // Level interrupt from unmasked sticky bits
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat_nxt & irq_mask_nxt);
        end
    end

endmodule

// ### inc/ges_pkg.sv
package ges_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;           // Byte address width
    localparam int DATA_W = 32;          // Bus data width

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00; // Enable control
    localparam logic [7:0] OFS_STATUS   = 8'h04; // State and flags
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08; // Sticky events, W1C
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c; // Event mask

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_W        = 2;    // Control field width
    localparam int CTRL_STAB_EN  = 0;    // Stabiliser enable bit
    localparam int CTRL_AUTO_EN  = 1;    // Autopilot enable bit
    localparam logic [1:0] CTRL_RST = 2'h3; // Both enables set
    localparam int STAT_STATE_LSB = 0;   // Engage state field
    localparam int STAT_FLAG_LSB  = 4;   // Display/stab/auto flags
    localparam int IRQ_W         = 3;    // Event count
    localparam int IRQ_CHANGE    = 0;    // Engage state changed
    localparam int IRQ_AUTO_OFF  = 1;    // Autopilot dropped out
    localparam int IRQ_DISP_LOST = 2;    // Display flag lost
    localparam logic [2:0] IRQ_MASK_RST = 3'h0; // All masked

    // ------------------------------------------------------------
    // Engage states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        GES_ALL_OFF,
        GES_DISP,
        GES_STAB,
        GES_DISP_STAB,
        GES_ALL_ON,
        GES_WHEEL
    } ges_state_t;

endpackage

// ### rtl/ges_sync.sv
`timescale 1ns/100ps
module ges_sync #(
    parameter int W = 1                  // Number of bits
) (
    input  wire logic         clk_sys_in, // System clock
    input  wire logic         rstn_in,    // Async reset, low
    input  wire logic [W-1:0] raw_in,     // Asynchronous levels
    output logic      [W-1:0] sync_out    // Synchronised levels
);

    // ------------------------------------------------------------
    // Two-flop synchroniser per bit
    // ------------------------------------------------------------
    logic [W-1:0] meta_r;                 // First stage, read only below

    for (genvar i = 0; i < W; i++) begin : g_bit
        // Stage chain for one bit
        always_ff @(posedge clk_sys_in or negedge rstn_in) begin
            if (!rstn_in) begin
                meta_r[i]   <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta_r[i]   <= raw_in[i];
                sync_out[i] <= meta_r[i];
            end
        end
    end

endmodule

// ### rtl/ges_press.sv
`timescale 1ns/100ps
module ges_press #(
    parameter int W = 1                   // Number of switches
) (
    input  wire logic         clk_sys_in, // System clock
    input  wire logic         rstn_in,    // Async reset, low
    input  wire logic [W-1:0] level_in,   // Synchronised switch levels
    output logic      [W-1:0] press_out   // One-cycle new-press pulse
);

    // ------------------------------------------------------------
    // Released-to-pressed detection
    // ------------------------------------------------------------
    logic [W-1:0] prev_r;                 // Level one cycle ago

    for (genvar i = 0; i < W; i++) begin : g_sw
        // Reset loads pressed, but the synchroniser resets low, so a switch held at reset still presses
        always_ff @(posedge clk_sys_in or negedge rstn_in) begin
            if (!rstn_in) begin
                prev_r[i] <= 1'b1;
            end else begin
                prev_r[i] <= level_in[i];
            end
        end
        // A press only after an observed released period
        assign press_out[i] = level_in[i] & ~prev_r[i];
    end

endmodule

// ### bench/ges_monitor.sv
`timescale 1ns/100ps
module ges_monitor (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic disp_btn_in,
    input wire logic stab_btn_in,
    input wire logic auto_btn_in,
    input wire logic wheel_sw_in,
    input wire logic dump_sw_in,
    input wire logic gyro_ok_in,
    input wire logic check_ok_in,
    input wire logic goaround_in,
    input wire logic trim_man_in,
    input wire logic trim_ok_in,
    input wire logic g_dump_in,
    input wire logic disp_on_out,
    input wire logic stab_on_out,
    input wire logic auto_on_out,
    input wire logic wheel_on_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    // ----------------------------------------
    // Held conditions, long enough to pass sync
    // ----------------------------------------
    sequence s_disp_bad; (!gyro_ok_in || !check_ok_in)[*5]; endsequence
    sequence s_trim_bad; (trim_man_in && !wheel_sw_in)[*5]; endsequence
    sequence s_held; (disp_btn_in && !stab_btn_in && !auto_btn_in && gyro_ok_in && check_ok_in)[*8]; endsequence
    a_start_all_off: assert property ($rose(rstn_in) |-> !disp_on_out && !stab_on_out && !auto_on_out)
        else $error("engage outputs not off after reset");
    a_disp_flag_off: assert property (s_disp_bad |-> !disp_on_out && !stab_on_out && !auto_on_out)
        else $error("engaged while display flag false");
    a_stab_dump_off: assert property (dump_sw_in[*5] |-> !stab_on_out && !auto_on_out)
        else $error("stabiliser on while dump pressed");
    a_auto_trim_off: assert property (s_trim_bad |-> !auto_on_out)
        else $error("autopilot on during manual trim");
    a_auto_goaround: assert property (goaround_in[*5] |-> !auto_on_out)
        else $error("autopilot on during go-around");
    a_auto_mon_off: assert property ((!trim_ok_in)[*5] |-> !auto_on_out)
        else $error("autopilot on with trim monitor bad");
    a_gdump_auto_off: assert property (g_dump_in[*5] |-> !auto_on_out)
        else $error("autopilot on during acceleration dump");
    a_auto_needs_all: assert property (auto_on_out |-> disp_on_out && stab_on_out)
        else $error("autopilot without display and stabiliser");
    a_wheel_needs_auto: assert property (wheel_on_out |-> auto_on_out)
        else $error("wheel steering without autopilot");
    a_held_no_repeat: assert property (s_held |=> $stable(disp_on_out))
        else $error("held button acted twice");
endmodule
bind ges_top ges_monitor mon_u (.*);

// ### bench/ges_cockpit_model.sv
`timescale 1ns/100ps
module ges_cockpit_model (
    input  wire logic       clk_sys_in, // System clock
    output logic      [2:0] btn_out,    // Display, stab, auto buttons
    output logic      [7:0] lvl_out     // Wheel,dump,gyro,check,goaround,trim_man,trim_ok,g_dump
);
    // Released buttons, healthy monitors
    initial begin
        btn_out = 3'h0;
        lvl_out = 8'h4c;
    end
    // Momentary press held for some cycles, then a release period
    task automatic press(input int idx, input int hold);
        @(posedge clk_sys_in);
        btn_out[idx] <= 1'b1;
        repeat (hold) @(posedge clk_sys_in);
        btn_out[idx] <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
    endtask
    // New held levels, then time to settle
    task automatic set_lvl(input logic [7:0] x);
        @(posedge clk_sys_in);
        lvl_out <= x;
        repeat (6) @(posedge clk_sys_in);
    endtask
endmodule

// ### bench/ges_top_tb_top.sv
`timescale 1ns/100ps
module ges_top_tb_top;
    import ges_pkg::*;
    logic        clk_sys_in = 1'b0; // Clock
    logic        rstn_in = 1'b0;    // Reset, low
    logic        wb_cyc_in = 1'b0;  // Bus request
    logic        wb_we_in = 1'b0;   // Write
    logic [7:0]  wb_adr_in = 8'h00; // Address
    logic [31:0] wb_dat_in = 32'h0; // Write data
    logic [31:0] wb_dat_out, rd;    // Read data
    logic        wb_ack_out, disp_on_out, stab_on_out, auto_on_out, wheel_on_out, irq_out;
    logic [2:0]  btn;               // Buttons
    logic [7:0]  lvl, v;            // Held levels, model copy
    logic [1:0]  en;                // Model enables
    int          st, error_cnt, cmp_count, i;
    int          tab [3][6] = '{'{1, 0, 3, 2, 4, 5}, '{2, 3, 0, 1, 1, 1}, '{4, 4, 4, 4, 3, 3}};
    int          seq [] = '{0, 1, 0, 1, 1, 0, 1, 0, 2, 2, 2, 1, 2, 0};
    int          flt [] = '{8'hcc, 8'h5c, 8'h6c, 8'h0c, 8'h4e, 8'h48, 8'h44, 8'h6d};
    always #25 clk_sys_in = ~clk_sys_in;
    ges_top dut_u (.clk_sys_in, .rstn_in, .wb_cyc_in, .wb_stb_in(wb_cyc_in), .wb_we_in, .wb_adr_in,
        .wb_sel_in(4'hf), .wb_dat_in, .wb_dat_out, .wb_ack_out, .disp_btn_in(btn[0]), .stab_btn_in(btn[1]),
        .auto_btn_in(btn[2]), .wheel_sw_in(lvl[0]), .dump_sw_in(lvl[1]), .gyro_ok_in(lvl[2]),
        .check_ok_in(lvl[3]), .goaround_in(lvl[4]), .trim_man_in(lvl[5]), .trim_ok_in(lvl[6]),
        .g_dump_in(lvl[7]), .disp_on_out, .stab_on_out, .auto_on_out, .wheel_on_out, .irq_out);
    ges_cockpit_model cockpit_u (.clk_sys_in, .btn_out(btn), .lvl_out(lvl));
    // Model permission flags {auto, stab, display}
    function automatic logic [2:0] flg();
        logic d, s;
        d = v[2] & v[3];
        s = d & !v[1] & en[0];
        return {s & !v[4] & (!v[5] | v[0]) & v[6] & en[1] & !v[7], s, d};
    endfunction
    // Model per-cycle overrides and wheel steering
    function automatic int ovr(int s);
        logic [2:0] f;
        f = flg();
        if (!f[0]) s = 0;
        else if (!f[1]) s = (s == 2) ? 0 : ((s >= 3) ? 1 : s);
        if (!f[2] && s >= 4) s = 3;
        if (s == 4 && v[0]) s = 5;
        else if (s == 5 && !v[0]) s = 4;
        return s;
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Classic single bus cycle, bounded wait for ack
    task automatic bus(logic we, logic [7:0] a, logic [31:0] d);
        int n = 0;
        @(posedge clk_sys_in);
        wb_cyc_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= a;
        wb_dat_in <= d;
        do @(posedge clk_sys_in); while (wb_ack_out !== 1'b1 && ++n < 20);
        if (n >= 20) begin
            chk("ack", 32'h1, 32'h0);
            close_out();
        end
        rd = wb_dat_out;
        wb_cyc_in <= 1'b0;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus(1'b1, a, d);
        repeat (3) @(posedge clk_sys_in);
    endtask
    // Outputs and status against the model
    task automatic cmp_st();
        logic [2:0] f;
        f = flg();
        chk("engage", {28'h0, st != 0 && st != 2, st >= 2, st >= 4, st == 5},
            {28'h0, disp_on_out, stab_on_out, auto_on_out, wheel_on_out});
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("status", {27'h0, f[0], 1'b0, 3'(st)}, {27'h0, rd[4:0]});
    endtask
    task automatic do_press(int b, int h);
        logic [2:0] f;
        cockpit_u.press(b, h);
        f = flg();
        st = ovr(st);
        if (b != 2 || f[2]) st = tab[b][st];
        st = ovr(st);
        cmp_st();
    endtask
    task automatic lv(logic [7:0] x);
        v = x;
        cockpit_u.set_lvl(x);
        st = ovr(st);
        cmp_st();
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        error_cnt = 0;
        cmp_count = 0;
        st = 0;
        v = 8'h4c;
        en = 2'h3;
        i = $urandom(32'h87f5);
        repeat (4) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        bus(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", 32'h3, rd);
        bus(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, rd);
        cmp_st();
        foreach (seq[k]) do_press(seq[k], 1 + k % 8);
        for (i = 0; i < 16; i++) begin
            lv({v[7:1], 1'($urandom_range(1, 0))});
            do_press($urandom_range(2, 0), $urandom_range(4, 1));
        end
        lv(8'h44);
        lv(8'h4c);
        foreach (flt[k]) begin
            do_press(2, 2);
            lv(flt[k][7:0]);
            lv(8'h4c);
        end
        wr(OFS_CTRL, 32'h1);
        en = 2'h1;
        st = ovr(st);
        cmp_st();
        do_press(2, 1);
        wr(OFS_CTRL, 32'h3);
        en = 2'h3;
        do_press(2, 1);
        wr(OFS_IRQ_MASK, 32'h0);
        wr(OFS_IRQ_STAT, 32'h7);
        do_press(1, 1);
        chk("irq masked", 32'h0, {31'h0, irq_out});
        bus(1'b0, OFS_IRQ_STAT, 32'h0);
        chk("irq stat", 32'h3, {29'h0, rd[2:0]});
        wr(OFS_IRQ_MASK, 32'h1);
        chk("irq on", 32'h1, {31'h0, irq_out});
        wr(OFS_IRQ_STAT, 32'h1);
        chk("irq cleared", 32'h0, {31'h0, irq_out});
        close_out();
    end
endmodule
